// ---- core/asrp_host.sv ----
// Purpose: host controller: makes conversion, load and shift clocks, reads words
// Assumes: Avalon-MM slave with waitrequest, writes at once, reads one wait
// Notes:   link clocks come from dividers on ref_clk
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "asrp_cfg.svh"
module asrp_host
   import asrp_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Link
   asrp_link_if.host        link,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   // Interrupt
   output      logic        irq
);
   localparam int CONV = `ASRP_CONV_CYC;
   localparam int HALF = (CONV + 1) / 2;
   localparam int SHC  = `ASRP_SHIFT_CYC;
   localparam int LDC  = `ASRP_LOAD_CYC;

   logic [2:0]  ctrl_r;
   logic [3:0]  stat_r, mask_r, ev;
   logic [9:0]  cdiv_r;
   logic [5:0]  tcnt_r;
   logic [3:0]  bit_r;
   logic [1:0]  sdo_s, uf_s, of_s;
   asrp_word_t  acc_r, data_r;
   logic [1:0]  rng_r, drng_r;
   logic        cclk_r, load_n_r, sclk_r;
   asrp_state_t st_r;
   logic        conv_rise;

   ////////////////////////////////////////////////////////////////////////
   // Conversion clock divider, 50 percent duty
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cdiv_r <= 10'h0;
         cclk_r <= 1'b0;
      end else if (!ctrl_r[`ASRP_CTRL_RUN]) begin
         cdiv_r <= 10'h0;
         cclk_r <= 1'b0;
      end else begin
         cdiv_r <= (cdiv_r == 10'(CONV - 1)) ? 10'h0 : cdiv_r + 10'h1;
         cclk_r <= (cdiv_r < 10'(HALF));
      end
   end
   assign conv_rise = ctrl_r[`ASRP_CTRL_RUN] & (cdiv_r == 10'h0);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sdo_s <= 2'h0;
         uf_s  <= 2'h0;
         of_s  <= 2'h0;
      end else begin
         sdo_s <= {sdo_s[0], link.serial_result_out};
         uf_s  <= {uf_s[0], link.under_range_flag};
         of_s  <= {of_s[0], link.over_range_flag};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Load and shift sequencer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r     <= ASRP_IDLE;
         tcnt_r   <= 6'h0;
         bit_r    <= 4'h0;
         load_n_r <= 1'b1;
         sclk_r   <= 1'b0;
         acc_r    <= '0;
         rng_r    <= 2'h0;
      end else begin
         unique case (st_r)
            ASRP_IDLE: begin
               if (conv_rise) begin
                  st_r     <= ASRP_LOAD;
                  load_n_r <= 1'b0;
                  tcnt_r   <= 6'h0;
               end
            end
            ASRP_LOAD: begin
               tcnt_r <= tcnt_r + 6'h1;
               // Extra cycles cover the device's input synchroniser
               if (tcnt_r == 6'(LDC + 3)) begin
                  load_n_r <= 1'b1;
                  rng_r    <= {of_s[1], uf_s[1]};
                  tcnt_r   <= 6'h0;
                  bit_r    <= 4'h0;
                  st_r     <= ASRP_SHIFT;
               end
            end
            ASRP_SHIFT: begin
               tcnt_r <= tcnt_r + 6'h1;
               if (tcnt_r == 6'(SHC / 2 + 2)) begin
                  // Sample bit before the rising edge that moves it on
                  acc_r  <= {acc_r[`ASRP_RES_W-2:0], sdo_s[1]};
                  sclk_r <= 1'b1;
               end
               if (tcnt_r == 6'(SHC + 4)) begin
                  sclk_r <= 1'b0;
                  tcnt_r <= 6'h0;
                  bit_r  <= bit_r + 4'h1;
                  if (bit_r == 4'(`ASRP_RES_W - 1)) begin
                     st_r <= ASRP_IDLE;
                  end
               end
            end
         endcase
      end
   end

   assign ev[`ASRP_ST_DONE]  = (st_r == ASRP_SHIFT) & (tcnt_r == 6'(SHC + 4))
                               & (bit_r == 4'(`ASRP_RES_W - 1));
   assign ev[`ASRP_ST_UNDER] = ev[`ASRP_ST_DONE] & rng_r[0];
   assign ev[`ASRP_ST_OVER]  = ev[`ASRP_ST_DONE] & rng_r[1];
   assign ev[`ASRP_ST_MISS]  = conv_rise & (st_r != ASRP_IDLE);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         data_r <= '0;
         drng_r <= 2'h0;
      end else if (ev[`ASRP_ST_DONE]) begin
         // Word and its flags are kept together until the next word is done
         data_r <= acc_r;
         drng_r <= rng_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   wire wr_ok = avs_write;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= 3'h0;
         mask_r <= 4'h0;
         stat_r <= 4'h0;
      end else begin
         if (wr_ok && avs_address == `ASRP_REG_CTRL) ctrl_r <= avs_writedata[2:0];
         if (wr_ok && avs_address == `ASRP_REG_MASK) mask_r <= avs_writedata[3:0];
         // Set wins over write-one clear
         if (wr_ok && avs_address == `ASRP_REG_STAT)
            stat_r <= (stat_r & ~avs_writedata[3:0]) | ev;
         else
            stat_r <= stat_r | ev;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h0;
      end else if (avs_read) begin
         unique case (avs_address)
            `ASRP_REG_CTRL: avs_readdata <= {29'h0, ctrl_r};
            `ASRP_REG_STAT: avs_readdata <= {28'h0, stat_r};
            `ASRP_REG_MASK: avs_readdata <= {28'h0, mask_r};
            `ASRP_REG_DATA: avs_readdata <= {18'h0, drng_r, data_r};
            default:        avs_readdata <= 32'h0;
         endcase
      end
   end

   // Read answers one cycle after request, write at once
   logic rd_done_r;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) rd_done_r <= 1'b0;
      else         rd_done_r <= avs_read & ~rd_done_r;
   end
   assign avs_waitrequest = avs_read & ~rd_done_r;

   assign irq                 = |(stat_r & mask_r);
   assign link.conv_clk       = cclk_r;
   assign link.shift_load_n   = load_n_r;
   assign link.shift_clk      = sclk_r;
   assign link.msb_invert_oe  = ctrl_r[`ASRP_CTRL_MSB_INVERT_IN];
   assign link.lsb_invert_oe  = ctrl_r[`ASRP_CTRL_LSB_INVERT_IN];
   assign link.msb_invert_drv = 1'b1;
   assign link.lsb_invert_drv = 1'b1;
endmodule : asrp_host

// ---- core/asrp_cfg.svh ----
// Purpose: constants for the serial result port, device end and host end
// Assumes: ref_clk at 250 MHz (4 ns)
// Notes:   timing figures are kept in their own unit, cycle counts derived
// Notes on behaviour
// - New result each conversion clock, 2.5-cycle latency
// - msb_invert_in high inverts the top bit
// - lsb_invert_in high inverts the lower bits
// - Undriven straps read low: straight binary
// - Conversion clock period at least 1.33 us
// - Load falls no earlier than conversion clock rise
// - Shift clock period at least 110 ns
// - Load strobe held low at least 50 ns
// - Load low copies result, overrides shift clock
// - Top bit first, next bit each shift rise
// - Under-range raises flag, forces negative full scale
// - Over-range raises flag, forces positive full scale
`ifndef ASRP_CFG_SVH
`define ASRP_CFG_SVH
`define ASRP_CLK_PERIOD_PS   4000
`define ASRP_RES_W           12
`define ASRP_CONV_PERIOD_NS  1330
`define ASRP_SHIFT_PERIOD_NS 110
`define ASRP_LOAD_WIDTH_NS   50
`define ASRP_CONV_CYC   (((`ASRP_CONV_PERIOD_NS*1000)+`ASRP_CLK_PERIOD_PS-1)/`ASRP_CLK_PERIOD_PS)
`define ASRP_SHIFT_CYC  (((`ASRP_SHIFT_PERIOD_NS*1000)+`ASRP_CLK_PERIOD_PS-1)/`ASRP_CLK_PERIOD_PS)
`define ASRP_LOAD_CYC   (((`ASRP_LOAD_WIDTH_NS*1000)+`ASRP_CLK_PERIOD_PS-1)/`ASRP_CLK_PERIOD_PS)
`define ASRP_REG_CTRL   4'h0
`define ASRP_REG_STAT   4'h4
`define ASRP_REG_MASK   4'h8
`define ASRP_REG_DATA   4'hc
`define ASRP_CTRL_RUN   0
`define ASRP_CTRL_MSB_INVERT_IN  1
`define ASRP_CTRL_LSB_INVERT_IN  2
`define ASRP_ST_DONE    0
`define ASRP_ST_UNDER   1
`define ASRP_ST_OVER    2
`define ASRP_ST_MISS    3
`define ASRP_EV_W       4
`endif

// ---- core/asrp_pkg.sv ----
// Purpose: shared types of the serial result port
// Assumes: constants come from asrp_cfg.svh
// Notes:   none
`include "asrp_cfg.svh"
package asrp_pkg;
   typedef logic [`ASRP_RES_W-1:0] asrp_word_t;
   typedef enum logic [1:0] {ASRP_IDLE, ASRP_LOAD, ASRP_SHIFT} asrp_state_t;
endpackage : asrp_pkg

// ---- core/asrp_link_if.sv ----
// Purpose: pins between converter end and host end
// Assumes: all signals plain levels; the device never tristates
// Notes:   straps are pulled low here when nobody drives them
`timescale 1ns/10ps
interface asrp_link_if;
   logic conv_clk;
   logic shift_load_n;
   logic shift_clk;
   logic serial_result_out;
   logic under_range_flag;
   logic over_range_flag;
   logic msb_invert_in;
   logic lsb_invert_in;
   logic msb_invert_oe;
   logic lsb_invert_oe;
   logic msb_invert_drv;
   logic lsb_invert_drv;
   // Weak pull-down: undriven strap reads low
   assign msb_invert_in = msb_invert_oe & msb_invert_drv;
   assign lsb_invert_in = lsb_invert_oe & lsb_invert_drv;
   modport dev (
      input  conv_clk, shift_load_n, shift_clk, msb_invert_in, lsb_invert_in,
      output serial_result_out, under_range_flag, over_range_flag
   );
   modport host (
      output conv_clk, shift_load_n, shift_clk, msb_invert_oe, lsb_invert_oe,
      output msb_invert_drv, lsb_invert_drv,
      input  serial_result_out, under_range_flag, over_range_flag
   );
endinterface : asrp_link_if

// ---- core/asrp_dev.sv ----
// Purpose: converter digital end: pipeline, format straps, load/shift register
// Assumes: link pins sampled by ref_clk through two flip-flops
// Notes:   analog sample is a parallel word plus range bits on the user side
`timescale 1ns/10ps
`include "asrp_cfg.svh"
module asrp_dev
   import asrp_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Link
   asrp_link_if.dev        link,
   // Sample source
   input  wire asrp_word_t sample_code,
   input  wire logic       sample_under,
   input  wire logic       sample_over,
   output      logic       sample_take
);
   localparam int W = `ASRP_RES_W;

   logic [1:0] cclk_s, load_s, sclk_s, msb_invert_in_s, lsb_invert_in_s;
   logic       cclk_d, sclk_d;
   logic       cclk_rise, cclk_fall, sclk_rise;
   asrp_word_t st1_r, st2_r, st3_r, par_r, sh_r;
   logic [1:0] rng1_r, rng2_r, rng3_r, rng_r;
   logic       sdo_r;

   function automatic asrp_word_t fmt(input asrp_word_t c, input logic mi, input logic li);
      fmt = {c[W-1] ^ mi, c[W-2:0] ^ {(W-1){li}}};
   endfunction : fmt

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cclk_s <= 2'h0;
         load_s <= 2'h3;
         sclk_s <= 2'h0;
         msb_invert_in_s <= 2'h0;
         lsb_invert_in_s <= 2'h0;
         cclk_d <= 1'b0;
         sclk_d <= 1'b0;
      end else begin
         cclk_s <= {cclk_s[0], link.conv_clk};
         load_s <= {load_s[0], link.shift_load_n};
         sclk_s <= {sclk_s[0], link.shift_clk};
         msb_invert_in_s <= {msb_invert_in_s[0], link.msb_invert_in};
         lsb_invert_in_s <= {lsb_invert_in_s[0], link.lsb_invert_in};
         cclk_d <= cclk_s[1];
         sclk_d <= sclk_s[1];
      end
   end
   assign cclk_rise   = cclk_s[1] & ~cclk_d;
   assign cclk_fall   = ~cclk_s[1] & cclk_d;
   assign sclk_rise   = sclk_s[1] & ~sclk_d;
   assign sample_take = cclk_fall;

   ////////////////////////////////////////////////////////////////////////
   // Pipeline: sample on fall, result out 2.5 periods later on a rise
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st1_r  <= '0;
         rng1_r <= 2'h0;
         st2_r  <= '0;
         rng2_r <= 2'h0;
         st3_r  <= '0;
         rng3_r <= 2'h0;
         par_r  <= '0;
         rng_r  <= 2'h0;
      end else begin
         if (cclk_fall) begin
            // Out of range forces full scale before formatting
            st1_r  <= sample_over ? '1 : (sample_under ? '0 : sample_code);
            rng1_r <= {sample_over, sample_under & ~sample_over};
            st2_r  <= st1_r;
            rng2_r <= rng1_r;
            st3_r  <= st2_r;
            rng3_r <= rng2_r;
         end
         // Two falls of delay plus the half period up to this rise
         if (cclk_rise) begin
            par_r <= fmt(st3_r, msb_invert_in_s[1], lsb_invert_in_s[1]);
            rng_r <= rng3_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift register: level load wins over shift clock
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sh_r  <= '0;
         sdo_r <= 1'b0;
      end else if (!load_s[1]) begin
         sh_r  <= par_r;
         sdo_r <= par_r[W-1];
      end else if (sclk_rise) begin
         sh_r  <= {sh_r[W-2:0], 1'b0};
         sdo_r <= sh_r[W-2];
      end
   end

   assign link.serial_result_out = sdo_r;
   assign link.over_range_flag   = rng_r[1];
   assign link.under_range_flag  = rng_r[0];
endmodule : asrp_dev

// ---- verif/asrp_link_sva.sv ----
// Purpose: link-pin checks between converter end and host end
// Assumes: ref_clk at 4 ns samples every pin but the two straps
// Notes:   limits are in ref_clk cycles
`timescale 1ns/10ps
module asrp_link_sva (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Link pins
   input wire logic conv_clk,
   input wire logic shift_load_n,
   input wire logic shift_clk,
   input wire logic serial_result_out,
   input wire logic under_range_flag,
   input wire logic over_range_flag
);
   localparam int CONV_MIN  = 332;
   localparam int SHIFT_MIN = 27;
   logic [15:0] conv_cnt_r;
   logic [7:0]  shift_cnt_r;
   logic [7:0]  quiet_cnt_r;
   logic [3:0]  bits_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles since conversion rise, shift rise, last load or shift; bits since load
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         conv_cnt_r  <= 16'hffff;
         shift_cnt_r <= 8'hff;
         quiet_cnt_r <= 8'h00;
         bits_r      <= 4'h0;
      end else begin
         conv_cnt_r  <= $rose(conv_clk) ? 16'h0000 : conv_cnt_r + {15'h0, conv_cnt_r != 16'hffff};
         shift_cnt_r <= $rose(shift_clk) ? 8'h00 : shift_cnt_r + {7'h0, shift_cnt_r != 8'hff};
         quiet_cnt_r <= (!shift_load_n || $rose(shift_clk)) ? 8'h00 :
                        quiet_cnt_r + {7'h0, quiet_cnt_r != 8'hff};
         if (!shift_load_n)
            bits_r <= 4'h0;
         else if ($rose(shift_clk))
            bits_r <= bits_r + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_conv_period; $rose(conv_clk) |-> conv_cnt_r >= CONV_MIN; endproperty
   a_conv_period: assert property (p_conv_period) else $error("conversion period short");
   property p_load_at_conv; $fell(shift_load_n) |-> conv_clk; endproperty
   a_load_at_conv: assert property (p_load_at_conv) else $error("load before conv rise");
   property p_shift_period; $rose(shift_clk) |-> shift_cnt_r >= SHIFT_MIN; endproperty
   a_shift_period: assert property (p_shift_period) else $error("shift period short");
   property p_load_width;
      $fell(shift_load_n) |=> !shift_load_n [*8] ##1 !shift_load_n [*4];
   endproperty
   a_load_width: assert property (p_load_width) else $error("load pulse short");
   property p_load_wins; $rose(shift_clk) |-> shift_load_n; endproperty
   a_load_wins: assert property (p_load_wins) else $error("shift during load");
   property p_sdo_quiet; $changed(serial_result_out) |-> quiet_cnt_r <= 8'h05; endproperty
   a_sdo_quiet: assert property (p_sdo_quiet) else $error("serial bit moved unprompted");
   property p_flags; !(under_range_flag && over_range_flag); endproperty
   a_flags: assert property (p_flags) else $error("both range flags high");
   property p_twelve; $rose(shift_clk) |-> bits_r < 4'hc; endproperty
   a_twelve: assert property (p_twelve) else $error("over twelve shifts per load");
   c_load: cover property ($fell(shift_load_n));
   c_under: cover property ($rose(under_range_flag));
   c_over: cover property ($rose(over_range_flag));
endmodule : asrp_link_sva

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench joining converter end and host end
// Assumes: host answers Avalon reads after one wait cycle
// Notes:   a fresh random sample at every conversion, at least six per case
`timescale 1ns/10ps
`include "asrp_cfg.svh"
module tb_top import asrp_pkg::*; ;
   logic        ref_clk;
   logic        resetn;
   asrp_word_t  sample_code;
   logic        sample_under;
   logic        sample_over;
   logic        sample_take;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        irq_a;
   logic [31:0] rd;
   logic [31:0] rnd;
   logic [13:0] smp_q[$];
   logic [13:0] exp_load;
   logic        m_sel;
   logic        l_sel;
   logic        ld_prev;
   int          n_fail;
   int          check_count;
   int          seed;
   int          take_cnt;
   int          gap;
   int          t0;
   // Twelve minimum shifts plus the load outlast one conversion period
   localparam logic [31:0] MISS_EXP =
      {31'h0, (`ASRP_LOAD_CYC + `ASRP_RES_W * `ASRP_SHIFT_CYC > `ASRP_CONV_CYC)};
   asrp_link_if u_asrp_link_if ();
   asrp_dev u_asrp_dev (.ref_clk(ref_clk), .resetn(resetn), .link(u_asrp_link_if),
      .sample_code(sample_code), .sample_under(sample_under), .sample_over(sample_over),
      .sample_take(sample_take));
   asrp_host u_asrp_host (.ref_clk(ref_clk), .resetn(resetn), .link(u_asrp_link_if),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq));
   asrp_link_sva u_asrp_link_sva (.ref_clk(ref_clk), .resetn(resetn),
      .conv_clk(u_asrp_link_if.conv_clk), .shift_load_n(u_asrp_link_if.shift_load_n),
      .shift_clk(u_asrp_link_if.shift_clk), .serial_result_out(u_asrp_link_if.serial_result_out),
      .under_range_flag(u_asrp_link_if.under_range_flag),
      .over_range_flag(u_asrp_link_if.over_range_flag));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // One Avalon transfer, entered just after a rising edge
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge ref_clk);
      end
      q = avs_readdata;
      if (avs_waitrequest !== 1'b0)
         check(32'h1, 32'h0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge ref_clk);
   endtask : av
   // Clear status, then poll until a word is done
   task automatic wait_done;
      av(1'b1, `ASRP_REG_STAT, 32'hf, rd);
      rd = '0;
      for (int k = 0; k < 2000 && rd[0] !== 1'b1; k++)
         av(1'b0, `ASRP_REG_STAT, 32'h0, rd);
      check({31'h0, rd[0]}, 32'h1);
   endtask : wait_done
   function automatic logic [13:0] fmt(input asrp_word_t c, input logic u, o, m, l);
      asrp_word_t w;
      w = o ? 12'hfff : (u ? 12'h000 : c);
      w[11] = w[11] ^ m;
      w[10:0] = w[10:0] ^ {11{l}};
      return {o, u, w};
   endfunction : fmt
   ////////////////////////////////////////////////////////////////////////////////
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      gap     <= gap + 1;
      ld_prev <= u_asrp_link_if.shift_load_n;
      if (resetn !== 1'b1) begin
         sample_code <= '0;
      end else if (sample_take === 1'b1) begin
         take_cnt <= take_cnt + 1;
         gap      <= 1;
         if (take_cnt > 0)
            check(gap, `ASRP_CONV_CYC);
         // Pipeline model: the last three samples taken
         smp_q.push_back({sample_over, sample_under, sample_code});
         if (smp_q.size() > 3)
            smp_q.pop_front();
         rnd = $random(seed);
         sample_code <= rnd[11:0];
      end
      // A load at a conversion rise carries the sample of three falls back
      if (ld_prev === 1'b1 && u_asrp_link_if.shift_load_n === 1'b0 && smp_q.size() == 3)
         exp_load <= fmt(smp_q[0][11:0], smp_q[0][12], smp_q[0][13], m_sel, l_sel);
   end
   initial begin
      #240000;
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      stop_test();
   end
   initial begin
      {n_fail, check_count, take_cnt, gap} = '0;
      seed = 32'h9ebf;
      {sample_under, sample_over, m_sel, l_sel} = '0;
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      resetn = 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      av(1'b0, 4'h2, 32'h0, rd);
      check(rd, 32'h0);
      for (int i = 0; i < 12; i++) begin
         m_sel <= i[0];
         l_sel <= i[1];
         av(1'b1, `ASRP_REG_CTRL, {29'h0, i[1], i[0], 1'b1}, rd);
         sample_under <= (i / 4 == 1);
         sample_over  <= (i / 4 == 2);
         t0 = take_cnt;
         while (take_cnt < t0 + 6)
            @(posedge ref_clk);
         wait_done();
         check({30'h0, rd[2:1]}, {30'h0, exp_load[13:12]});
         av(1'b0, `ASRP_REG_DATA, 32'h0, rd);
         check({18'h0, rd[13:0]}, {18'h0, exp_load});
         $display("case %0d done", i);
      end
      av(1'b1, `ASRP_REG_STAT, 32'hf, rd);
      t0 = take_cnt;
      while (take_cnt < t0 + 3)
         @(posedge ref_clk);
      av(1'b0, `ASRP_REG_STAT, 32'h0, rd);
      check({31'h0, rd[3]}, MISS_EXP);
      av(1'b1, `ASRP_REG_MASK, 32'h0, rd);
      @(negedge ref_clk);
      irq_a = irq;
      @(posedge ref_clk);
      check({31'h0, irq_a}, 32'h0);
      av(1'b1, `ASRP_REG_MASK, 32'hf, rd);
      @(negedge ref_clk);
      check({31'h0, irq}, 32'h1);
      @(posedge ref_clk);
      // Right after a finished word no event is due for several hundred cycles
      wait_done();
      av(1'b1, `ASRP_REG_STAT, 32'hf, rd);
      @(negedge ref_clk);
      check({31'h0, irq}, 32'h0);
      $display("interrupt test done");
      stop_test();
   end
endmodule : tb_top
